// ==== test_vsio_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "vsio_defines.svh"
// ----------------------------------------
// self-checking bench for the discrete io block
// ----------------------------------------
module test_vsio_top;
  import vsio_pkg::*;
  localparam int PCYC = 20;
  localparam int SCYC = 10;
  localparam logic [11:0] ST = `VSIO_OFS_STATUS;
  localparam logic [11:0] LP = `VSIO_OFS_LOGPTR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sourcing_strap;
  logic insp_done, fatal_error, fire_trig, fire_teach, trig_pin, teach_pin;
  logic trig_event, teach_event, insp_busy, fail_hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] out_pin;
  logic [65:0] mq;
  logic [65:0] exp_q[$];
  logic [15:0] lf;
  vsio_result_t insp_result, r, last;
  int err_total, checks_done, tc, hc, c, wp;
  vsio_top #(.PULSE_CYC(PCYC), .SEC_CYC(SCYC)) u_vsio_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin(trig_pin), .teach_pin(teach_pin), .sourcing_strap(sourcing_strap),
    .insp_done(insp_done), .insp_result(insp_result), .fatal_error(fatal_error), .trig_event(trig_event),
    .teach_event(teach_event), .insp_busy(insp_busy), .out_pin(out_pin), .fail_hold(fail_hold));
  vsio_ctl_model u_vsio_ctl_model (.pclk(pclk), .presetn(presetn), .fire_trig(fire_trig),
    .fire_teach(fire_teach), .trig_pin(trig_pin), .teach_pin(teach_pin));
  // clock
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic vsio_result_t rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return {lf[15:14], lf};
  endfunction
  // apb transfer; the expectation is queued for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, m, e, input logic er);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    exp_q.push_back({w, er, m, e});
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin @(posedge pclk); if (pready === 1'b1) break; end
    if (n == 20) begin err_total++; give_verdict; end
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d, 0, 0, 0); endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, e); apb(0, a, 0, m, e, 0); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(0, a, 0, '1, e, 0); endtask
  task automatic fire(input bit t);
    @(posedge pclk);
    if (t) fire_teach <= 1; else fire_trig <= 1;
    @(posedge pclk);
    fire_teach <= 0; fire_trig <= 0;
  endtask
  task automatic done(input vsio_result_t res);
    @(posedge pclk);
    insp_done <= 1; insp_result <= res;
    @(posedge pclk);
    insp_done <= 0;
    tick(8);
  endtask
  task automatic insp(input vsio_result_t res);
    int n;
    fire(0);
    for (n = 0; n < 30; n++) begin @(posedge pclk); if (insp_busy === 1'b1) break; end
    if (n == 30) begin err_total++; give_verdict; end
    done(res);
  endtask
  task ferr;
    @(posedge pclk); fatal_error <= 1;
    @(posedge pclk); fatal_error <= 0;
  endtask
  function automatic logic exp_o(logic [2:0] s, logic an, logic [7:0] mk, vsio_result_t x);
    logic [7:0] m, ok;
    m = mk & x.tool_def;
    ok = (s == 3'h2 ? x.tool_pass : ~x.tool_pass) & m;
    case (s)
      3'h0: return x.pass;
      3'h1: return !x.pass;
      3'h4: return x.sort1;
      default: return an ? ok != 8'h0 : (m != 8'h0 && ok == m);
    endcase
  endfunction
  // monitor: oldest note against each completed access
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      mq = exp_q.pop_front();
      if (!mq[65]) chk("prdata", mq[31:0], prdata & mq[63:32]);
      // status reads also hold the pins themselves against the expectation
      if (!mq[65] && paddr == ST) chk("pins", mq[31:0] & mq[63:32] & 32'h79,
        {fail_hold, out_pin, 2'h0, insp_busy} & mq[63:32] & 32'h79);
      chk("pslverr", {31'h0, mq[64]}, {31'h0, pslverr});
    end
    tc += trig_event === 1'b1;
    hc += teach_event === 1'b1;
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, insp_done, insp_result, fatal_error} = '0;
    {fire_trig, fire_teach, sourcing_strap, presetn} = '0;
    lf = 16'h1dd2;
    tick(2);
    presetn <= 1;
    tick(2);
    rd(0, 0);
    sourcing_strap <= 1;
    presetn <= 0;
    tick(2);
    presetn <= 1;
    tick(2);
    rd(0, 1);
    for (int i = 1; i < 4; i++) rd(4 * i, 0);
    rd(`VSIO_OFS_PULSE, PCYC);
    apb(1, 12'h100, '1, 0, 0, 1);
    apb(0, 12'h100, 0, '1, 0, 1);
    // polarity against early and late edge of one pulse
    for (int p = 0; p < 2; p++) begin
      wr(0, p);
      for (int t = 0; t < 2; t++) begin
        c = t ? hc : tc;
        fire(t);
        tick(5);
        chk("edge early", p, (t ? hc : tc) - c);
        tick(9);
        chk("edge late", 1, (t ? hc : tc) - c);
        if (t == 0) done(0);
      end
    end
    wr(8, 5);
    wr(12, 6);
    fire(0);
    tick(12);
    fire(0);
    tick(12);
    rdm(ST, 'h12, 'h12);
    ferr;
    rdm(ST, 'h24, 'h24);
    wr(`VSIO_OFS_CMD, 2);
    rdm(ST, 'h36, 'h12);
    ferr;
    wr(`VSIO_OFS_CMD, 1);
    rdm(ST, 'h36, 0);
    done(0);
    for (int s = 0; s < 5; s++) for (int a = 0; a < 2; a++) for (int k = 0; k < 3; k++) begin
      r = rnd();
      wr(4, {lf[11:4], a[0], 1'b0, s[2:0]});
      insp(r);
      rdm(ST, 'h8, {exp_o(s[2:0], a[0], lf[11:4], r), 3'h0});
    end
    wr(4, 'h8);
    r = rnd();
    r.pass = 1;
    insp(r);
    rdm(ST, 'h8, 'h8);
    tick(PCYC + 5);
    rdm(ST, 'h8, 0);
    wr(`VSIO_OFS_HOLD, 4000);
    rd(`VSIO_OFS_HOLD, 3600);
    wr(`VSIO_OFS_HOLD, 2);
    r.pass = 0;
    insp(r);
    rdm(ST, 'h40, 'h40);
    r.pass = 1;
    insp(r);
    tick(25);
    rdm(ST, 'h40, 0);
    wr(0, 7);
    for (int i = 0; i < 12; i++) begin
      last = rnd();
      insp(last);
    end
    wp = 2;
    for (int md = 0; md < 4; md++) begin
      wr(0, {md[1:0], 1'b1});
      for (int f = 0; f < 2; f++) begin
        r = rnd();
        r.pass = !f[0];
        insp(r);
        if (md[f]) begin wp = (wp + 1) % 10; last = r; end
      end
      rdm(LP, 'hff0, {4'ha, wp[3:0], 4'h0});
    end
    wr(LP, (wp + 9) % 10);
    rd(`VSIO_OFS_LOGDATA, last);
    wr(LP, 10);
    rd(`VSIO_OFS_LOGDATA, 0);
    give_verdict;
  end
endmodule
`default_nettype wire

// ==== vsio_ctl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// machine controller driving trigger and teach
// ----------------------------------------
module vsio_ctl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pulse requests
  input wire logic fire_trig,
  input wire logic fire_teach,
  // pins
  output logic     trig_pin,
  output logic     teach_pin
);
  logic [3:0] tcnt_r;
  logic [3:0] hcnt_r;
  // eight-cycle pulses, wide enough for the sync to see both edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_r <= 4'h0;
      hcnt_r <= 4'h0;
    end else begin
      tcnt_r <= fire_trig ? 4'h8 : tcnt_r - (tcnt_r != 4'h0);
      hcnt_r <= fire_teach ? 4'h8 : hcnt_r - (hcnt_r != 4'h0);
    end
  end
  assign trig_pin  = tcnt_r != 4'h0;
  assign teach_pin = hcnt_r != 4'h0;
endmodule
`default_nettype wire

// ==== vsio_defines.svh ====
// Overview of operation
// - trigger and teach inputs act only on edges, never on levels
// - rising polarity: event only on a low to high input transition
// - falling polarity: event only on a high to low input transition
// - polarity resets from sourcing strap: rising if sourcing, falling if sinking
// - each of three outputs selects its own source
// - trigger while inspection busy flags missed trigger
// - missed trigger stays set until statistics history reset
// - fatal error sets and holds system error
// - system error clears on history reset or clear fault command
// - output one resets to inspection pass, latched
// - pulse width defaults to fifty milliseconds
// - latched output holds until a later result changes it
// - all-of: every checked defined tool must meet criterion
// - any-of: at least one checked defined tool meets criterion
// - undefined tool positions are excluded from combination
// - fail hold display timer runs 0 to 3600 seconds after a failure
// - fail hold timer never blocks trigger processing
// - log holds ten records, newest overwriting oldest
// - logging mode: disabled, pass only, fail only, all
`ifndef VSIO_DEFINES_SVH
`define VSIO_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define VSIO_OFS_CTRL      12'h000
`define VSIO_OFS_OUTCFG0   12'h004
`define VSIO_OFS_OUTCFG1   12'h008
`define VSIO_OFS_OUTCFG2   12'h00c
`define VSIO_OFS_PULSE     12'h010
`define VSIO_OFS_HOLD      12'h014
`define VSIO_OFS_CMD       12'h018
`define VSIO_OFS_STATUS    12'h01c
`define VSIO_OFS_LOGPTR    12'h020
`define VSIO_OFS_LOGDATA   12'h040

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define VSIO_CTRL_POL_BIT   0
`define VSIO_CTRL_LOG_LSB   1
`define VSIO_CMD_HIST_BIT   0
`define VSIO_CMD_CLRF_BIT   1

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define VSIO_PULSE_MS       50
`define VSIO_CLK_HZ         10000000
`define VSIO_PULSE_CYC      (`VSIO_PULSE_MS * (`VSIO_CLK_HZ / 1000))
`define VSIO_HOLD_MAX_S     3600
`define VSIO_SEC_CYC        `VSIO_CLK_HZ
`define VSIO_LOG_DEPTH      10

`endif

// ==== vsio_log_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// small log memory, registered read
// ------------------------------------------------------------
module vsio_log_mem #(
  parameter int DEPTH = 10,
  parameter int WIDTH = 18,
  parameter int AW    = 4
) (
  // clock
  input  wire logic             pclk,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: contents only matter once written
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
  end
endmodule
`default_nettype wire

// ==== vsio_pkg.sv ====
package vsio_pkg;
  typedef enum logic [2:0] {
    VSIO_SRC_INSP_PASS, VSIO_SRC_INSP_FAIL, VSIO_SRC_TOOL_PASS, VSIO_SRC_TOOL_FAIL,
    VSIO_SRC_SORT1, VSIO_SRC_MISSED, VSIO_SRC_SYSERR
  } vsio_src_t;

  typedef struct packed {
    logic [7:0] tool_mask;
    logic       any_of;
    logic       pulsed;
    vsio_src_t  src;
  } vsio_outcfg_t;

  typedef struct packed {
    logic       pass;
    logic       sort1;
    logic [7:0] tool_pass;
    logic [7:0] tool_def;
  } vsio_result_t;
endpackage

// ==== vsio_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "vsio_defines.svh"
module vsio_top #(
  parameter int PULSE_CYC = `VSIO_PULSE_CYC,
  parameter int SEC_CYC   = `VSIO_SEC_CYC,
  parameter int NTOOL     = 8
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pins and strap
  input  wire logic                  trig_pin,
  input  wire logic                  teach_pin,
  input  wire logic                  sourcing_strap,
  // inspection engine
  input  wire logic                  insp_done,
  input  wire vsio_pkg::vsio_result_t insp_result,
  input  wire logic                  fatal_error,
  output logic                       trig_event,
  output logic                       teach_event,
  output logic                       insp_busy,
  // discrete outputs and display
  output logic      [2:0]            out_pin,
  output logic                       fail_hold
);
  import vsio_pkg::*;

  localparam logic [31:0] HOLD_MAX = 32'(`VSIO_HOLD_MAX_S);

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic [1:0] trg_s_r, trg_s_nxt, tch_s_r, tch_s_nxt, stp_s_r, stp_s_nxt, stp_cnt_r, stp_cnt_nxt;
  logic       trg_d_r, tch_d_r;
  logic       pol_r, pol_nxt;  // 1 = rising

  always_comb begin
    trg_s_nxt = {trg_s_r[0], trig_pin};
    tch_s_nxt = {tch_s_r[0], teach_pin};
    stp_s_nxt = {stp_s_r[0], sourcing_strap};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_s_r <= 2'h0;
      tch_s_r <= 2'h0;
      stp_s_r <= 2'h0;
      trg_d_r <= 1'b0;
      tch_d_r <= 1'b0;
    end else begin
      trg_s_r <= trg_s_nxt;
      tch_s_r <= tch_s_nxt;
      stp_s_r <= stp_s_nxt;
      trg_d_r <= trg_s_r[1];
      tch_d_r <= tch_s_r[1];
    end
  end

  // only transitions count; a held level never repeats an event
  always_comb begin
    if (pol_r) begin
      trig_event  = trg_s_r[1] & ~trg_d_r;
      teach_event = tch_s_r[1] & ~tch_d_r;
    end else begin
      trig_event  = ~trg_s_r[1] & trg_d_r;
      teach_event = ~tch_s_r[1] & tch_d_r;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  vsio_outcfg_t cfg_r [3];
  vsio_outcfg_t cfg_nxt [3];
  logic [1:0]  logmode_r, logmode_nxt;
  logic [31:0] pulse_r, pulse_nxt, hold_r, hold_nxt;
  logic        wr_acc, hist_clr, fault_clr;

  assign wr_acc    = psel & penable & pwrite;
  assign hist_clr  = wr_acc && paddr == `VSIO_OFS_CMD && pwdata[`VSIO_CMD_HIST_BIT];
  assign fault_clr = wr_acc && paddr == `VSIO_OFS_CMD && pwdata[`VSIO_CMD_CLRF_BIT];

  // config writes; strap picks polarity on the third edge after release
  always_comb begin
    pol_nxt     = pol_r;
    logmode_nxt = logmode_r;
    pulse_nxt   = pulse_r;
    hold_nxt    = hold_r;
    for (int i = 0; i < 3; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    // wait for the strap synchroniser to fill before its value is trusted
    stp_cnt_nxt = (stp_cnt_r == 2'h3) ? 2'h3 : stp_cnt_r + 2'h1;
    if (stp_cnt_r == 2'h2) begin
      pol_nxt = stp_s_r[1];
    end
    if (wr_acc) begin
      case (paddr)
        `VSIO_OFS_CTRL: begin
          pol_nxt     = pwdata[`VSIO_CTRL_POL_BIT];
          logmode_nxt = pwdata[`VSIO_CTRL_LOG_LSB +: 2];
        end
        `VSIO_OFS_OUTCFG0: cfg_nxt[0] = vsio_outcfg_t'(pwdata[12:0]);
        `VSIO_OFS_OUTCFG1: cfg_nxt[1] = vsio_outcfg_t'(pwdata[12:0]);
        `VSIO_OFS_OUTCFG2: cfg_nxt[2] = vsio_outcfg_t'(pwdata[12:0]);
        `VSIO_OFS_PULSE:   pulse_nxt  = (pwdata == 32'h0) ? 32'h1 : pwdata;
        `VSIO_OFS_HOLD:    hold_nxt   = (pwdata > HOLD_MAX) ? HOLD_MAX : pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stp_cnt_r    <= 2'h0;
      pol_r        <= 1'b1;
      logmode_r    <= 2'h0;
      pulse_r      <= 32'(PULSE_CYC);
      hold_r       <= 32'h0;
      for (int i = 0; i < 3; i++) begin
        cfg_r[i] <= '{tool_mask: 8'h00, any_of: 1'b0, pulsed: 1'b0, src: VSIO_SRC_INSP_PASS};
      end
    end else begin
      stp_cnt_r    <= stp_cnt_nxt;
      pol_r        <= pol_nxt;
      logmode_r    <= logmode_nxt;
      pulse_r      <= pulse_nxt;
      hold_r       <= hold_nxt;
      for (int i = 0; i < 3; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------
  // busy, missed trigger, system error
  // ------------------------------------------------------------
  logic busy_r, busy_nxt, missed_r, missed_nxt, syserr_r, syserr_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    busy_nxt = busy_r;
    if (insp_done) busy_nxt = 1'b0;
    if (trig_event && !busy_r) busy_nxt = 1'b1;
    missed_nxt = hist_clr ? 1'b0 : missed_r;
    if (trig_event && busy_r) missed_nxt = 1'b1;
    syserr_nxt = (hist_clr || fault_clr) ? 1'b0 : syserr_r;
    if (fatal_error) syserr_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r   <= 1'b0;
      missed_r <= 1'b0;
      syserr_r <= 1'b0;
    end else begin
      busy_r   <= busy_nxt;
      missed_r <= missed_nxt;
      syserr_r <= syserr_nxt;
    end
  end
  assign insp_busy = busy_r;

  // ------------------------------------------------------------
  // per-output source, combination and pulse timing
  // ------------------------------------------------------------
  logic [2:0]  out_r;
  logic [31:0] pcnt_r [3];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_out
      logic [NTOOL-1:0] use_m, met_m;
      logic             tool_ok, want, res_evt, o_nxt;
      logic [31:0]      c_nxt;
      logic             crit_fail;

      assign crit_fail = (cfg_r[g].src == VSIO_SRC_TOOL_FAIL);
      // undefined positions drop out of both all-of and any-of
      assign use_m = cfg_r[g].tool_mask & insp_result.tool_def;
      assign met_m = use_m & (crit_fail ? ~insp_result.tool_pass : insp_result.tool_pass);
      assign tool_ok = cfg_r[g].any_of ? (|met_m)
                                       : ((use_m != '0) && (met_m == use_m));

      always_comb begin
        case (cfg_r[g].src)
          VSIO_SRC_INSP_PASS: want = insp_result.pass;
          VSIO_SRC_INSP_FAIL: want = ~insp_result.pass;
          VSIO_SRC_TOOL_PASS: want = tool_ok;
          VSIO_SRC_TOOL_FAIL: want = tool_ok;
          VSIO_SRC_SORT1:     want = insp_result.sort1;
          default:            want = 1'b0;
        endcase
      end
      assign res_evt = insp_done;

      always_comb begin
        o_nxt = out_r[g];
        c_nxt = pcnt_r[g];
        if (cfg_r[g].src == VSIO_SRC_MISSED) begin
          o_nxt = missed_r;
        end else if (cfg_r[g].src == VSIO_SRC_SYSERR) begin
          o_nxt = syserr_r;
        end else if (!cfg_r[g].pulsed) begin
          if (res_evt) o_nxt = want;
        end else if (res_evt && want) begin
          o_nxt = 1'b1;
          c_nxt = pulse_r;
        end else if (c_nxt > 32'h1) begin
          c_nxt = c_nxt - 32'h1;
        end else begin
          o_nxt = 1'b0;
          c_nxt = 32'h0;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_r[g]  <= 1'b0;
          pcnt_r[g] <= 32'h0;
        end else begin
          out_r[g]  <= o_nxt;
          pcnt_r[g] <= c_nxt;
        end
      end
    end
  endgenerate
  assign out_pin = out_r;

  // ------------------------------------------------------------
  // fail hold display timer, separate from trigger path
  // ------------------------------------------------------------
  logic [31:0] sec_r, sec_nxt, hsec_r, hsec_nxt;
  logic        fh_r, fh_nxt;

  always_comb begin
    sec_nxt  = sec_r;
    hsec_nxt = hsec_r;
    fh_nxt   = fh_r;
    if (insp_done && !insp_result.pass && hold_r != 32'h0) begin
      fh_nxt   = 1'b1;
      hsec_nxt = hold_r;
      sec_nxt  = 32'(SEC_CYC - 1);
    end else if (fh_r) begin
      if (sec_r != 32'h0) begin
        sec_nxt = sec_r - 32'h1;
      end else if (hsec_r > 32'h1) begin
        hsec_nxt = hsec_r - 32'h1;
        sec_nxt  = 32'(SEC_CYC - 1);
      end else begin
        fh_nxt = 1'b0;
      end
    end
  end

  // display only; busy and triggers never look at this
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r  <= 32'h0;
      hsec_r <= 32'h0;
      fh_r   <= 1'b0;
    end else begin
      sec_r  <= sec_nxt;
      hsec_r <= hsec_nxt;
      fh_r   <= fh_nxt;
    end
  end
  assign fail_hold = fh_r;

  // ------------------------------------------------------------
  // inspection log ring
  // ------------------------------------------------------------
  logic [3:0]  wp_r, wp_nxt, cnt_r, cnt_nxt, rsel_r, rsel_nxt;
  logic        log_we;
  logic [17:0] log_q;

  always_comb begin
    case (logmode_r)
      2'h1:    log_we = insp_done & insp_result.pass;
      2'h2:    log_we = insp_done & ~insp_result.pass;
      2'h3:    log_we = insp_done;
      default: log_we = 1'b0;
    endcase
    wp_nxt  = wp_r;
    cnt_nxt = cnt_r;
    if (log_we) begin
      wp_nxt = (wp_r == 4'(`VSIO_LOG_DEPTH - 1)) ? 4'h0 : wp_r + 4'h1;
      if (cnt_r != 4'(`VSIO_LOG_DEPTH)) cnt_nxt = cnt_r + 4'h1;
    end
    rsel_nxt = (wr_acc && paddr == `VSIO_OFS_LOGPTR) ? pwdata[3:0] : rsel_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r   <= 4'h0;
      cnt_r  <= 4'h0;
      rsel_r <= 4'h0;
    end else begin
      wp_r   <= wp_nxt;
      cnt_r  <= cnt_nxt;
      rsel_r <= rsel_nxt;
    end
  end

  vsio_log_mem #(.DEPTH(`VSIO_LOG_DEPTH), .WIDTH(18), .AW(4)) u_log (
    .pclk    (pclk),
    .wr_en   (log_we),
    .wr_addr (wp_r),
    .wr_data ({insp_result.pass, insp_result.sort1, insp_result.tool_pass, insp_result.tool_def}),
    .rd_addr (rsel_r),
    .rd_data (log_q)
  );

  // ------------------------------------------------------------
  // apb read mux, zero wait, slverr on unmapped
  // ------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic        map_ok;

  always_comb begin
    map_ok = 1'b1;
    case (paddr)
      `VSIO_OFS_CTRL:    rd_nxt = {29'h0, logmode_r, pol_r};
      `VSIO_OFS_OUTCFG0: rd_nxt = {19'h0, cfg_r[0]};
      `VSIO_OFS_OUTCFG1: rd_nxt = {19'h0, cfg_r[1]};
      `VSIO_OFS_OUTCFG2: rd_nxt = {19'h0, cfg_r[2]};
      `VSIO_OFS_PULSE:   rd_nxt = pulse_r;
      `VSIO_OFS_HOLD:    rd_nxt = hold_r;
      `VSIO_OFS_CMD:     rd_nxt = 32'h0;
      `VSIO_OFS_STATUS:  rd_nxt = {25'h0, fh_r, out_r, syserr_r, missed_r, busy_r};
      `VSIO_OFS_LOGPTR:  rd_nxt = {20'h0, cnt_r, wp_r, rsel_r};
      `VSIO_OFS_LOGDATA: rd_nxt = {14'h0, log_q};
      default: begin
        rd_nxt = 32'h0;
        map_ok = 1'b0;
      end
    endcase
    prdata  = (psel && penable && !pwrite) ? rd_nxt : 32'h0;
    pready  = 1'b1;
    pslverr = psel & penable & ~map_ok;
  end
endmodule
`default_nettype wire

// ==== vsio_top_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checks for the discrete io block
// ----------------------------------------
module vsio_top_checker (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  // pins and engine
  input wire logic                   trig_pin,
  input wire logic                   teach_pin,
  input wire logic                   insp_done,
  input wire vsio_pkg::vsio_result_t insp_result,
  input wire logic                   trig_event,
  input wire logic                   teach_event,
  input wire logic                   insp_busy,
  input wire logic                   fail_hold
);
  import vsio_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // an event needs a pin transition behind the two-flop sync
  a_trig_src: assert property (trig_event |->
    $past(trig_pin, 2) != $past(trig_pin, 3) || $past(trig_pin, 3) != $past(trig_pin, 4))
    else $error("trigger event without pin edge");
  a_teach_src: assert property (teach_event |->
    $past(teach_pin, 2) != $past(teach_pin, 3) || $past(teach_pin, 3) != $past(teach_pin, 4))
    else $error("teach event without pin edge");
  a_event_once: assert property (trig_event |=> !trig_event)
    else $error("trigger event longer than one cycle");
  // hold on the display must never stall acceptance
  a_busy_set: assert property (trig_event && !insp_busy |=> insp_busy)
    else $error("idle trigger not accepted");
  a_busy_clr: assert property (insp_done |-> ##[1:2] !insp_busy)
    else $error("busy not cleared after done");
  a_hold_cause: assert property ($rose(fail_hold) |->
    ($past(insp_done) && !$past(insp_result.pass)) || ($past(insp_done, 2) && !$past(insp_result.pass, 2)))
    else $error("fail hold without failed result");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
endmodule
bind vsio_top vsio_top_checker u_vsio_top_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .trig_pin(trig_pin),
  .teach_pin(teach_pin), .insp_done(insp_done), .insp_result(insp_result), .trig_event(trig_event),
  .teach_event(teach_event), .insp_busy(insp_busy), .fail_hold(fail_hold));
`default_nettype wire
